// *** hw/reset_controller.sv ***
// Top of the reset controller: sequences power-on, brown-out and the other resets.
// Assumes analog detector levels and request inputs are synchronous to i_clk_sys.
`timescale 1ns/100ps
module reset_controller #(
  parameter int unsigned PWRUP_CYCLES  = reset_ctrl_pkg::PWRUP_CYCLES,
  parameter int unsigned FILTER_CYCLES = reset_ctrl_pkg::FILTER_CYCLES
) (
  input  wire logic                           i_clk_sys,
  input  wire logic                           i_reset,
  input  wire logic                           i_por_low,
  input  wire logic                           i_brownout_low,
  input  wire logic                           i_brownout_ready,
  input  wire reset_ctrl_pkg::brownout_mode_t i_brownout_mode_sel,
  input  wire logic                           i_powerup_delay_enable_n,
  input  wire logic                           i_osc_start_done,
  input  wire logic                           i_sleep,
  input  wire reset_ctrl_pkg::reset_req_t     i_reset_req,
  input  wire reset_ctrl_pkg::reg_req_t       i_reg,
  output logic [7:0]                          o_rdata,
  output logic                                o_brownout_enable,
  output logic                                o_core_reset,
  output logic                                o_wake_ok,
  output logic                                o_power_event
);
  import reset_ctrl_pkg::*;

  seq_state_t state;
  seq_state_t next_state;
  logic       sw_brownout_enable;
  logic       next_sw_brownout_enable;
  logic [7:0] next_rdata;
  logic       next_core_reset;
  logic       next_brownout_enable;
  logic       next_wake_ok;
  logic       next_power_event;
  logic       detector_on;
  logic       trip;
  logic       power_cond;
  logic       timer_done;
  logic       other_req;
  logic       start_waits;
  logic       ready_gate;

  // Which modes keep the detector powered, given sleep and the software bit.
  always_comb begin
    unique case (i_brownout_mode_sel)
      MODE_ALWAYS_ON:    detector_on = 1'b1;
      MODE_OFF_IN_SLEEP: detector_on = !i_sleep;
      MODE_SOFTWARE:     detector_on = sw_brownout_enable;
      default:           detector_on = 1'b0;
    endcase
  end

  // Forced-on modes wait for detector ready; software and off modes never do.
  assign start_waits = (i_brownout_mode_sel == MODE_ALWAYS_ON) ||
                       (i_brownout_mode_sel == MODE_OFF_IN_SLEEP);
  assign ready_gate  = !start_waits || (i_brownout_ready && !i_brownout_low);

  brownout_filter #(
    .CYCLES (FILTER_CYCLES)
  ) u_filter (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_low     (i_brownout_low && detector_on && i_brownout_ready),
    .o_trip    (trip)
  );

  // Power condition: the power-on detector low or a filtered brown-out trip.
  assign power_cond = i_por_low || trip;
  assign other_req  = |i_reset_req;

  powerup_delay_timer #(
    .CYCLES (PWRUP_CYCLES)
  ) u_timer (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_run     (state == ST_TIMING),
    .o_done    (timer_done)
  );

  // Sequencer: power hold, then timer, then ready wait, then run.
  always_comb begin
    next_state = state;
    case (state)
      ST_POWER_HOLD: begin
        if (!power_cond) begin
          next_state = i_powerup_delay_enable_n ? ST_WAIT_READY : ST_TIMING;
        end
      end
      ST_TIMING: begin
        if (power_cond) begin
          next_state = ST_POWER_HOLD;
        end else if (timer_done) begin
          next_state = ST_WAIT_READY;
        end
      end
      ST_WAIT_READY: begin
        if (power_cond) begin
          next_state = ST_POWER_HOLD;
        end else if (ready_gate && i_osc_start_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (power_cond) begin
          next_state = ST_POWER_HOLD;
        end
      end
      default: next_state = ST_POWER_HOLD;
    endcase
  end

  // Software bit returns to one on each power event; other resets keep it.
  always_comb begin
    next_sw_brownout_enable = sw_brownout_enable;
    if (state == ST_POWER_HOLD) begin
      next_sw_brownout_enable = BROWNOUT_CONTROL_RST[BIT_SW_ENABLE];
    end else if (i_reg.wr && i_reg.addr == ADDR_BROWNOUT_CONTROL) begin
      next_sw_brownout_enable = i_reg.wdata[BIT_SW_ENABLE];
    end
  end

  // Register reads; data stand the cycle after the strobe, zero otherwise.
  always_comb begin
    next_rdata = 8'h00;
    if (i_reg.rd) begin
      case (i_reg.addr)
        ADDR_BROWNOUT_CONTROL: begin
          next_rdata[BIT_SW_ENABLE] = sw_brownout_enable;
          next_rdata[BIT_READY]     = detector_on && i_brownout_ready;
        end
        ADDR_CONFIG_STATUS: begin
          next_rdata = {4'h0, state, i_brownout_mode_sel};
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Registered outputs; any other request resets the core without the timer.
  always_comb begin
    next_core_reset      = (next_state != ST_RUN) || other_req;
    next_brownout_enable = detector_on;
    next_wake_ok         = (i_brownout_mode_sel != MODE_OFF_IN_SLEEP) ||
                           i_brownout_ready;
    next_power_event     = (state == ST_POWER_HOLD);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state              <= ST_POWER_HOLD;
      sw_brownout_enable <= BROWNOUT_CONTROL_RST[BIT_SW_ENABLE];
      o_rdata            <= 8'h00;
      o_core_reset       <= 1'b1;
      o_brownout_enable  <= 1'b0;
      o_wake_ok          <= 1'b0;
      o_power_event      <= 1'b1;
    end else begin
      state              <= next_state;
      sw_brownout_enable <= next_sw_brownout_enable;
      o_rdata            <= next_rdata;
      o_core_reset       <= next_core_reset;
      o_brownout_enable  <= next_brownout_enable;
      o_wake_ok          <= next_wake_ok;
      o_power_event      <= next_power_event;
    end
  end

  a_por_holds_core : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_por_low |=> o_core_reset)
    else $error("Core left reset while power-on detector low.");
  a_req_resets_core : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    other_req |=> o_core_reset)
    else $error("Reset request did not reset the core.");
  a_timer_holds_core : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == ST_TIMING |=> o_core_reset)
    else $error("Core released while power-up timer running.");
  a_timer_after_power : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == ST_POWER_HOLD && power_cond |=> state == ST_POWER_HOLD)
    else $error("Timer started before power conditions released.");
  a_bypass_skips_timer : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == ST_POWER_HOLD && i_powerup_delay_enable_n |=> state != ST_TIMING)
    else $error("Timer ran although bypassed.");
  a_forced_ready_start : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == ST_WAIT_READY && start_waits && !i_brownout_ready |=> state != ST_RUN)
    else $error("Start without detector ready in forced mode.");
  a_sw_bit_restore : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state == ST_POWER_HOLD |=> sw_brownout_enable)
    else $error("Software enable not restored on power event.");
  a_ready_read_zero : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_reg.rd && i_reg.addr == ADDR_BROWNOUT_CONTROL && !detector_on |=> !o_rdata[0])
    else $error("Ready bit set with detector off.");
  a_off_mode_inactive : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_brownout_mode_sel == MODE_ALWAYS_OFF |=> !o_brownout_enable)
    else $error("Detector on in always-off mode.");

  c_full_start : cover property (@(posedge i_clk_sys) disable iff (i_reset)
    state == ST_TIMING ##1 state == ST_WAIT_READY ##1 state == ST_RUN);
  c_brownout_trip : cover property (@(posedge i_clk_sys) disable iff (i_reset)
    state == ST_RUN ##1 trip);
  c_sw_disable : cover property (@(posedge i_clk_sys) disable iff (i_reset)
    i_brownout_mode_sel == MODE_SOFTWARE && !sw_brownout_enable);
endmodule

// *** include/reset_ctrl_pkg.sv ***
// Constants, types and register layout for the brown-out and power-up reset controller.
// Assumes a single 125 MHz system clock and a plain address/strobe register port.
// Function
// - Any of six reset requests forces a core reset.
// - Power-on detector low keeps the core in reset.
// - Enabled power-up timer gives nominal 64 ms after power-on or brown-out.
// - Core stays in reset while the power-up timer runs.
// - Active-low enable bit clear enables timer; set bypasses it.
// - Timer starts only once power-on and brown-out conditions are released.
// - Active detector reporting low supply holds the core in reset.
// - Two-bit mode field picks four modes; code 00 is always off.
// - Mode 11 keeps detector on; start waits for ready and good supply.
// - Always-on mode protects in sleep and does not delay wake-up.
// - Mode 10 detector on except sleep; start waits for ready and supply.
// - Off-in-sleep mode delays wake-up until detector ready again.
// - Mode 01 lets software bit control detector; start never waits.
// - Software mode protects once ready; ready bit mirrors detector state.
// - In software mode sleep does not change protection.
// - Reset only when supply stays low longer than the filter time.
// - Outside mode 01 the software bit is stored but has no effect.
// - In mode 01 bit 7 enables detector; resets to 1 on power events.
// - Read-only bit 0 reads 1 when detector active, else 0.
// - Forced-on modes have ready set before the core starts executing.
// - Start needs timer done, oscillator start-up done and pin released.
package reset_ctrl_pkg;

  localparam int unsigned CLK_HZ           = 125_000_000;
  localparam int unsigned PWRUP_TIME_MS    = 64;
  localparam int unsigned PWRUP_CYCLES     = PWRUP_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned FILTER_TIME_NS   = 1000;
  localparam int unsigned FILTER_CYCLES    = (FILTER_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam logic [3:0] ADDR_BROWNOUT_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CONFIG_STATUS    = 4'h1;
  localparam int unsigned BIT_SW_ENABLE        = 7;
  localparam int unsigned BIT_READY            = 0;
  localparam logic [7:0]  BROWNOUT_CONTROL_RST = 8'h80;

  typedef enum logic [1:0] {
    MODE_ALWAYS_OFF   = 2'b00,
    MODE_SOFTWARE     = 2'b01,
    MODE_OFF_IN_SLEEP = 2'b10,
    MODE_ALWAYS_ON    = 2'b11
  } brownout_mode_t;

  typedef enum logic [1:0] {
    ST_POWER_HOLD = 2'b00,
    ST_TIMING     = 2'b01,
    ST_WAIT_READY = 2'b10,
    ST_RUN        = 2'b11
  } seq_state_t;

  // Requests that end in a plain core reset without restarting the timer.
  typedef struct packed {
    logic ext_pin;
    logic watchdog;
    logic instruction;
    logic stack_over;
    logic stack_under;
    logic prog_exit;
  } reset_req_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

// *** hw/brownout_filter.sv ***
// Glitch filter on the brown-out comparator output.
// Assumes the comparator level is already synchronous to the clock.
`timescale 1ns/100ps
module brownout_filter #(
  parameter int unsigned CYCLES = reset_ctrl_pkg::FILTER_CYCLES
) (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  input  wire logic i_low,
  output logic      o_trip
);
  import reset_ctrl_pkg::*;

  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        next_trip;

  // Count consecutive low cycles; any good cycle restarts the count.
  always_comb begin
    next_cnt  = cnt;
    next_trip = 1'b0;
    if (!i_low) begin
      next_cnt = 16'h0000;
    end else if (cnt < 16'(CYCLES)) begin
      next_cnt = cnt + 16'h0001;
    end else begin
      next_trip = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cnt    <= 16'h0000;
      o_trip <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      o_trip <= next_trip;
    end
  end

  a_short_dip_ignored : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !i_low |=> !o_trip)
    else $error("Brown-out trip without sustained low supply.");
endmodule

// *** hw/powerup_delay_timer.sv ***
// Power-up delay counter: runs once started and flags done at terminal count.
// Assumes a start level that stays high while the count should run.
`timescale 1ns/100ps
module powerup_delay_timer #(
  parameter int unsigned CYCLES = reset_ctrl_pkg::PWRUP_CYCLES
) (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  input  wire logic i_run,
  output logic      o_done
);
  import reset_ctrl_pkg::*;

  logic [31:0] cnt;
  logic [31:0] next_cnt;

  // Restarting on a dropped run level gives a full delay after each event.
  always_comb begin
    next_cnt = 32'h0;
    if (i_run) begin
      next_cnt = (cnt < CYCLES) ? cnt + 32'h1 : cnt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cnt <= 32'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign o_done = i_run && (cnt >= CYCLES);

  a_timer_not_early : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !i_run ##1 i_run |-> !o_done)
    else $error("Power-up timer done right after start.");
endmodule

// *** testbench/detector_model.sv ***
// Behavioural power-on and brown-out detectors facing the reset controller.
// Assumes the bench commands supply state; outputs change just after a rising edge.
`timescale 1ns/100ps
module detector_model #(
  parameter int unsigned READY_DELAY = 3
) (
  input  wire logic i_clk_sys,
  input  wire logic i_supply_good,
  input  wire logic i_dip,
  input  wire logic i_ready_hold,
  input  wire logic i_enable,
  output logic      o_por_low,
  output logic      o_brownout_low,
  output logic      o_brownout_ready
);
  int unsigned settle = 0;
  logic        por_q  = 1'b1;
  logic        low_q  = 1'b0;
  logic        rdy_q  = 1'b0;

  // Known start values keep an unknown enable from freezing the comparator level.
  assign o_por_low        = por_q;
  assign o_brownout_low   = low_q;
  assign o_brownout_ready = rdy_q;

  // Ready rises only after the detector has been powered for a while; an unpowered
  // comparator gives a toggling level, so the controller must not trust it.
  always @(posedge i_clk_sys) begin
    por_q <= !i_supply_good;
    settle <= (i_enable === 1'b1) ? ((settle < READY_DELAY) ? settle + 1 : settle) : 0;
    rdy_q <= (i_enable === 1'b1) && !i_ready_hold && (settle >= READY_DELAY);
    low_q <= (i_enable === 1'b1) ? i_dip : !low_q;
  end
endmodule

// *** testbench/tb_reset_controller.sv ***
// Self-checking bench for the reset controller with a detector model on its far side.
// Assumes shortened power-up and filter counts so the run stays brief.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module tb_reset_controller;
  import reset_ctrl_pkg::*;
  localparam int unsigned PW = 20;
  localparam int unsigned FL = 4;
  logic           i_clk_sys = 0, i_reset = 1, en_n = 0, sleep = 0, good = 0, dip = 0, hold = 0;
  brownout_mode_t mode = MODE_ALWAYS_OFF;
  reset_req_t     req = '0;
  reg_req_t       rq = '0;
  logic [7:0]     o_rdata, d;
  logic           por_low, bo_low, bo_rdy, bo_en, core_rst, wake, pev;
  int             errors = 0, comparisons = 0, cyc = 0, n, seed = 32'hd54a0ee8;
  logic           sw, osc = 1;

  reset_controller #(.PWRUP_CYCLES(PW), .FILTER_CYCLES(FL)) u_reset_controller (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_por_low(por_low), .i_brownout_low(bo_low),
    .i_brownout_ready(bo_rdy), .i_brownout_mode_sel(mode), .i_powerup_delay_enable_n(en_n),
    .i_osc_start_done(osc), .i_sleep(sleep), .i_reset_req(req), .i_reg(rq),
    .o_rdata(o_rdata), .o_brownout_enable(bo_en), .o_core_reset(core_rst),
    .o_wake_ok(wake), .o_power_event(pev));
  detector_model u_detector_model (.i_clk_sys(i_clk_sys), .i_supply_good(good), .i_dip(dip),
    .i_ready_hold(hold), .i_enable(bo_en), .o_por_low(por_low), .o_brownout_low(bo_low),
    .o_brownout_ready(bo_rdy));

  initial begin
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // Hang guard: the whole sequence needs far fewer cycles than this.
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk_sys) rq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys) rq <= '0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_clk_sys) rq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys) rq <= '0;
    #1 v = o_rdata;
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge i_clk_sys);
    #1;
  endtask
  // Counts cycles until the core leaves reset, bounded.
  task automatic wait_run();
    n = 0;
    while (core_rst === 1'b1 && n < 300) begin
      @(posedge i_clk_sys);
      #1 n++;
    end
  endtask
  function automatic logic exp_en(brownout_mode_t m, logic s, logic sl);
    return (m == MODE_ALWAYS_ON) || (m == MODE_OFF_IN_SLEEP && !sl) || (m == MODE_SOFTWARE && s);
  endfunction
  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_reset <= 0;
    cycles(2);
    `CHK("core_rst_after_reset", 1'b1, core_rst)
    `CHK("power_event_after_reset", 1'b1, pev)
    rd(ADDR_BROWNOUT_CONTROL, d);
    `CHK("sw_enable_reset", 1'b1, d[7])
    // Enabled timer stretches reset after supply release.
    cycles(10);
    `CHK("held_while_por_low", 1'b1, core_rst)
    @(posedge i_clk_sys) good <= 1;
    wait_run();
    `CHK("pwrup_length", 1'b1, n >= PW && n <= PW + 8)
    // Bypassed timer releases quickly after a new power event.
    // Oscillator start-up still pending keeps the core held after a bypassed timer.
    @(posedge i_clk_sys) begin good <= 0; en_n <= 1; osc <= 0; end
    cycles(4);
    `CHK("power_event_on_por", 1'b1, pev)
    @(posedge i_clk_sys) good <= 1;
    cycles(10);
    `CHK("osc_start_wait", 1'b1, core_rst)
    @(posedge i_clk_sys) osc <= 1;
    wait_run();
    `CHK("bypass_length", 1'b1, n < 3)
    // Each non-power request gives a plain reset with no timer.
    for (int i = 0; i < 6; i++) begin
      @(posedge i_clk_sys) req <= reset_req_t'(6'h01 << i);
      @(posedge i_clk_sys) req <= '0;
      #1 `CHK("req_resets_core", 1'b1, core_rst)
      `CHK("req_no_power_event", 1'b0, pev)
      wait_run();
      `CHK("req_release", 1'b1, n < 8)
    end
    // Forced-on mode waits for detector ready before running.
    @(posedge i_clk_sys) begin mode <= MODE_ALWAYS_ON; en_n <= 0; hold <= 1; good <= 0; end
    cycles(4);
    @(posedge i_clk_sys) good <= 1;
    cycles(PW + 30);
    `CHK("wait_ready", 1'b1, core_rst)
    @(posedge i_clk_sys) hold <= 0;
    wait_run();
    `CHK("ready_release", 1'b1, n < 10)
    rd(ADDR_BROWNOUT_CONTROL, d);
    `CHK("ready_set_at_start", 1'b1, d[0])
    rd(ADDR_CONFIG_STATUS, d);
    `CHK("status_run", 8'h0f, d)
    rd(4'h5, d);
    `CHK("unmapped_zero", 8'h00, d)
    // A short dip is filtered, a long one trips back to power hold.
    @(posedge i_clk_sys) dip <= 1;
    repeat (FL) @(posedge i_clk_sys);
    dip <= 0;
    cycles(10);
    `CHK("short_dip_ignored", 1'b0, pev)
    @(posedge i_clk_sys) dip <= 1;
    cycles(FL + 4);
    `CHK("long_dip_trips", 1'b1, pev)
    `CHK("long_dip_core", 1'b1, core_rst)
    @(posedge i_clk_sys) dip <= 0;
    wait_run();
    `CHK("recover_after_dip", 1'b1, n >= PW)
    // Random modes, sleep and software enable writes.
    for (int k = 0; k < 16; k++) begin
      @(posedge i_clk_sys) begin
        mode <= brownout_mode_t'(2'($random(seed)));
        sleep <= 1'($random(seed));
      end
      sw = 1'($random(seed));
      wr(ADDR_BROWNOUT_CONTROL, {sw, 7'($random(seed))});
      cycles(8);
      `CHK("enable_mode", exp_en(mode, sw, sleep), bo_en)
      `CHK("wake_ok", !(mode == MODE_OFF_IN_SLEEP && sleep), wake)
      `CHK("no_reset", 1'b0, core_rst)
      rd(ADDR_BROWNOUT_CONTROL, d);
      `CHK("control_read", {sw, 6'h00, exp_en(mode, sw, sleep)}, d)
    end
    tally_and_finish();
  end
endmodule
